// >>> logic/stage_params.svh
// constants of the pump staging sequencer: register indices, fields, resets, timing
// assumes a 25 MHz system clock; included by bare name
`ifndef STAGE_PARAMS_SVH
`define STAGE_PARAMS_SVH

// clock and timer tick
`define CLK_PERIOD_NS 40
`define TICK_PERIOD_NS 100000000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)

// register indices; byte address is four times the index
`define IX_CTRL 4'h0
`define IX_SETPOINT 4'h1
`define IX_STAGE_LAG 4'h2
`define IX_DESTAGE_LAG 4'h3
`define IX_STAGE_DELAY 4'h4
`define IX_DESTAGE_DELAY 4'h5
`define IX_STAGE_TIME 4'h6
`define IX_DESTAGE_TIME 4'h7
`define IX_CYCLE_TIME 4'h8
`define IX_MIN_FREQ 4'h9
`define IX_MAX_FREQ 4'hA
`define IX_DESTAGE_WINDOW 4'hB
`define IX_BOOST 4'hC
`define IX_SPEED_CUT 4'hD
`define IX_STATUS 4'hE
`define NUM_CFG 14

// control register fields
`define CTRL_LAG_MSB 2
`define CTRL_LAG_LSB 0
`define CTRL_JOCKEY_BIT 3
`define MAX_LAG 3'h4

// status register fields
`define ST_RELAY_LSB 0
`define ST_MASTER_BIT 4
`define ST_PRIMARY_LSB 5
`define ST_LEVEL_LSB 8
`define ST_STATE_LSB 11

// reset values
`define CFG_RESET 24'h000000
`define PRDATA_RESET 32'h00000000
`define SPEED_RESET 16'h0000

`endif

// >>> logic/stage_pkg.sv
// types shared by the staging sequencer files
// assumes stage_params.svh supplies the numeric constants
package stage_pkg;
    // drive index: 0 is the master, 1..4 the relay-switched drives
    typedef logic [2:0] drive_t;

    // staging order with its length
    typedef struct packed {
        drive_t [4:0] slot;
        logic [2:0] len;
    } order_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_STAGE_HOLD = 2'b01,
        ST_DEST_RAISE = 2'b10,
        ST_DEST_HOLD = 2'b11
    } seq_state_e;
endpackage

// >>> logic/timer_if.sv
// carrier between the sequencer and one qualifying interval timer
// assumes the sequencer owns condition and limit, the timer answers done
`timescale 1ns/1ps
interface timer_if;
    logic run;
    logic [23:0] limit;
    logic done;
    modport owner (output run, output limit, input done);
    modport timer (input run, input limit, output done);
endinterface

// >>> logic/interval_timer.sv
// interval timer counting shared ticks while its condition holds
// assumes a one-cycle tick pulse from the sequencer's prescaler
`timescale 1ns/1ps
module interval_timer (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // shared tick
    input wire logic tick,
    // owner side
    timer_if.timer tif
);
    logic [23:0] count_reg;

    // any lapse of the condition restarts the count from zero
    always_ff @(posedge clk) begin
        if (!nrst) begin
            count_reg <= 24'h000000;
        end else if (!tif.run) begin
            count_reg <= 24'h000000;
        end else if (tick && count_reg < tif.limit) begin
            count_reg <= count_reg + 24'h000001;
        end
    end

    // compare with >= so that lowering the limit mid-count still ends it
    assign tif.done = tif.run && (count_reg >= tif.limit);
endmodule // interval_timer

// >>> logic/pump_stage_sequencer.sv
// pump staging sequencer: lead/lag and multiplex relay staging with speed overrides
// assumes an APB master, synchronous process inputs and a 25 MHz clock
//
// Overview of operation
// - no staging unless lag count nonzero
// - plain mode stages relays ascending from one
// - stage needs value at or below setpoint-lag
// - stage also needs stage delay elapsed
// - destage needs value high and delay elapsed
// - destage needs frequency inside minimum window
// - raise speed before releasing the relay
// - hold boost for destage time after release
// - after boost return to pressure loop
// - relays one to N serve staging
// - multiplex needs lag count and cycle time
// - multiplex requests slaves by closing relays
// - rotate primary each cycle time, wrapping
// - master stages second when not primary
// - order: primary, master, then cyclic slaves
// - destaging walks the order in reverse
// - primary drive skips the stage delay
// - staging cuts speed to max minus cut
// - staging overrides other relay functions
// - jockey relay one skipped, never primary
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
`include "stage_params.svh"
module pump_stage_sequencer #(
    parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // process measurements
    input wire logic [15:0] process_value,
    input wire logic [15:0] master_freq,
    // drive outputs
    output logic [3:0] relay,
    output logic master_run,
    output logic speed_override,
    output logic [15:0] speed_target
);
    import stage_pkg::*;

    logic [23:0] cfg_reg [`NUM_CFG];
    logic [31:0] prdata_reg;
    logic [31:0] tick_cnt_reg;
    logic tick;
    seq_state_e state_reg;
    seq_state_e state_next;
    logic [2:0] level_reg;
    drive_t primary_reg;
    logic [3:0] relay_reg;
    logic master_run_reg;
    logic override_reg;
    logic [15:0] speed_reg;
    logic [2:0] lag_n;
    logic jockey;
    logic stage_en;
    logic mux_on;
    logic below;
    logic above;
    logic in_window;
    logic stage_go;
    logic dest_go;
    logic rot_take;
    logic rot_hit_reg;
    logic [16:0] stage_cut;
    logic [16:0] boost_sum;
    logic [15:0] process_setpoint;
    logic [15:0] addition_speed_cut;
    logic [3:0] idx;
    logic addr_ok;
    order_s ord;
    drive_t next_primary;
    timer_if t_stage ();
    timer_if t_dest ();
    timer_if t_hold ();
    timer_if t_rot ();

    // configuration fields
    assign lag_n = cfg_reg[`IX_CTRL][`CTRL_LAG_MSB:`CTRL_LAG_LSB];
    assign jockey = cfg_reg[`IX_CTRL][`CTRL_JOCKEY_BIT];
    assign process_setpoint = cfg_reg[`IX_SETPOINT][15:0];
    assign addition_speed_cut = cfg_reg[`IX_SPEED_CUT][15:0];
    assign stage_en = (lag_n != 3'h0);
    assign mux_on = stage_en && (cfg_reg[`IX_CYCLE_TIME] != 24'h000000);

    // apb decode: word aligned, indices up to status
    assign idx = paddr[5:2];
    assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[7:6] == 2'h0) && (idx <= `IX_STATUS);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign prdata = prdata_reg;

    // register writes take effect in the access phase; lag count saturates at four
    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int i = 0; i < `NUM_CFG; i++) begin
                cfg_reg[i] <= `CFG_RESET;
            end
        end else if (psel && penable && pwrite && addr_ok && idx != `IX_STATUS) begin
            if (idx == `IX_CTRL && pwdata[`CTRL_LAG_MSB:`CTRL_LAG_LSB] > `MAX_LAG) begin
                cfg_reg[idx] <= {pwdata[23:3], `MAX_LAG};
            end else begin
                cfg_reg[idx] <= pwdata[23:0];
            end
        end
    end

    // read data is captured in the setup phase so it comes from a flip-flop
    always_ff @(posedge clk) begin
        if (!nrst) begin
            prdata_reg <= `PRDATA_RESET;
        end else if (psel && !penable) begin
            if (!addr_ok) begin
                prdata_reg <= `PRDATA_RESET;
            end else if (idx == `IX_STATUS) begin
                prdata_reg <= {19'h00000, state_reg, level_reg, primary_reg,
                               master_run_reg, relay_reg};
            end else begin
                prdata_reg <= {8'h00, cfg_reg[idx]};
            end
        end
    end

    // tick prescaler shared by all interval timers
    always_ff @(posedge clk) begin
        if (!nrst || tick) begin
            tick_cnt_reg <= 32'h00000000;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
        end
    end
    assign tick = (tick_cnt_reg == TICK_CYCLES - 1);

    // staging order: primary, master second, then slaves cyclic after primary
    function automatic order_s build_order(input logic [2:0] n, input drive_t p,
                                           input logic jk, input logic mx);
        order_s o;
        logic [3:0] t;
        o.slot = '0;
        o.len = 3'h0;
        t = 4'h0;
        if (mx) begin
            o.slot[o.len] = p;
            o.len = o.len + 3'h1;
            if (p != 3'h0) begin
                o.slot[o.len] = 3'h0;
                o.len = o.len + 3'h1;
            end
        end
        for (int k = 1; k <= 4; k++) begin
            t = (mx && p != 3'h0) ? 4'({1'b0, p}) + 4'(k) : 4'(k);
            if (t > {1'b0, n}) begin
                t = t - {1'b0, n};
            end
            // plain mode walks relays upward from the first; jockey relay left out
            if (k <= n && !(mx && t[2:0] == p) && !(jk && t[2:0] == 3'h1)) begin
                o.slot[o.len] = t[2:0];
                o.len = o.len + 3'h1;
            end
        end
        return o;
    endfunction

    assign ord = build_order(lag_n, primary_reg, jockey, mux_on);

    // threshold comparisons in 17 bits so lags never wrap
    assign below = ({1'b0, process_value} + {1'b0, cfg_reg[`IX_STAGE_LAG][15:0]})
                   <= {1'b0, process_setpoint};
    assign above = {1'b0, process_value} >=
                   ({1'b0, process_setpoint} + {1'b0, cfg_reg[`IX_DESTAGE_LAG][15:0]});
    assign in_window = (master_freq >= cfg_reg[`IX_MIN_FREQ][15:0]) &&
                       ({1'b0, master_freq} <= ({1'b0, cfg_reg[`IX_MIN_FREQ][15:0]} +
                       {1'b0, cfg_reg[`IX_DESTAGE_WINDOW][15:0]}));

    // stage and destage delay timers run only while idle and the condition holds; the hold timer runs in both hold states
    assign t_stage.run = stage_en && below && state_reg == ST_IDLE;
    assign t_stage.limit = cfg_reg[`IX_STAGE_DELAY];
    assign t_dest.run = stage_en && above && in_window && state_reg == ST_IDLE;
    assign t_dest.limit = cfg_reg[`IX_DESTAGE_DELAY];
    assign t_hold.run = (state_reg == ST_STAGE_HOLD) || (state_reg == ST_DEST_HOLD);
    assign t_hold.limit = (state_reg == ST_STAGE_HOLD) ? cfg_reg[`IX_STAGE_TIME]
                                                       : cfg_reg[`IX_DESTAGE_TIME];
    // rotation timer rests one cycle after each step; a combinational rest would loop
    always_ff @(posedge clk) begin
        rot_hit_reg <= nrst && rot_take;
    end
    assign t_rot.run = mux_on && !rot_hit_reg;
    assign t_rot.limit = cfg_reg[`IX_CYCLE_TIME];

    interval_timer stage_delay_timer (.clk(clk), .nrst(nrst), .tick(tick), .tif(t_stage));
    interval_timer destage_delay_timer (.clk(clk), .nrst(nrst), .tick(tick), .tif(t_dest));
    interval_timer hold_timer (.clk(clk), .nrst(nrst), .tick(tick), .tif(t_hold));
    interval_timer rotation_timer (.clk(clk), .nrst(nrst), .tick(tick), .tif(t_rot));

    // request decisions; the primary of a multiplex set skips the delay
    assign stage_go = stage_en && below && level_reg < ord.len &&
                      (t_stage.done || (mux_on && level_reg == 3'h0));
    assign dest_go = !stage_go && level_reg != 3'h0 && t_dest.done;
    assign rot_take = state_reg == ST_IDLE && t_rot.done;

    // sequencer state: a new request is looked at only from idle
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (stage_go) begin
                    state_next = ST_STAGE_HOLD;
                end else if (dest_go) begin
                    state_next = ST_DEST_RAISE;
                end
            end
            ST_STAGE_HOLD: begin
                if (t_hold.done) begin
                    state_next = ST_IDLE;
                end
            end
            ST_DEST_RAISE: begin
                state_next = ST_DEST_HOLD;
            end
            ST_DEST_HOLD: begin
                if (t_hold.done) begin
                    state_next = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // staged depth; release happens one cycle after the boost took hold
    always_ff @(posedge clk) begin
        if (!nrst || !stage_en) begin
            level_reg <= 3'h0;
        end else if (state_reg == ST_IDLE && stage_go) begin
            level_reg <= level_reg + 3'h1;
        end else if (state_reg == ST_DEST_RAISE) begin
            level_reg <= level_reg - 3'h1;
        end else if (state_reg == ST_IDLE && level_reg > ord.len) begin
            level_reg <= ord.len; // shrunk configuration drops the excess drives
        end
    end

    // primary rotation, wrapping after the last slave; jockey never primary
    always_comb begin
        next_primary = (primary_reg >= lag_n) ? 3'h0 : primary_reg + 3'h1;
        if (jockey && next_primary == 3'h1) begin
            next_primary = (lag_n >= 3'h2) ? 3'h2 : 3'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst || !mux_on) begin
            primary_reg <= 3'h0;
        end else if (rot_take) begin
            primary_reg <= next_primary;
        end
    end

    // relay per drive: closed while the drive sits in the staged part of the order
    generate
        for (genvar g = 0; g < 4; g++) begin : relay_gen
            logic member;
            always_comb begin
                member = 1'b0;
                for (int i = 0; i < 5; i++) begin
                    if (3'(i) < level_reg && ord.slot[i] == 3'(g + 1)) begin
                        member = 1'b1;
                    end
                end
            end
            // staging owns the relay outright, other relay uses have no path here
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    relay_reg[g] <= 1'b0;
                end else begin
                    relay_reg[g] <= stage_en && member;
                end
            end
        end
    endgenerate

    // master runs always in plain mode, in multiplex only once staged
    always_ff @(posedge clk) begin
        if (!nrst) begin
            master_run_reg <= 1'b1;
        end else if (!mux_on) begin
            master_run_reg <= 1'b1;
        end else begin
            master_run_reg <= (ord.slot[0] == 3'h0 && level_reg != 3'h0) ||
                              (ord.slot[1] == 3'h0 && level_reg > 3'h1);
        end
    end

    // speed override targets, saturating at both ends
    assign stage_cut = {1'b0, cfg_reg[`IX_MAX_FREQ][15:0]} - {1'b0, addition_speed_cut};
    assign boost_sum = {1'b0, master_freq} + {1'b0, cfg_reg[`IX_BOOST][15:0]};

    always_ff @(posedge clk) begin
        if (!nrst) begin
            speed_reg <= `SPEED_RESET;
            override_reg <= 1'b0;
        end else begin
            override_reg <= state_next != ST_IDLE;
            if (state_reg == ST_IDLE && stage_go) begin
                speed_reg <= stage_cut[16] ? 16'h0000 : stage_cut[15:0];
            end else if (state_reg == ST_IDLE && dest_go) begin
                speed_reg <= boost_sum[16] ? 16'hFFFF : boost_sum[15:0];
            end
        end
    end

    assign relay = relay_reg;
    assign master_run = master_run_reg;
    assign speed_override = override_reg;
    assign speed_target = speed_reg;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence dest_start_s;
        state_reg == ST_IDLE && state_next == ST_DEST_RAISE;
    endsequence
    sequence boost_then_release_s;
        ##1 (state_reg == ST_DEST_RAISE && speed_override) ##1
        (state_reg == ST_DEST_HOLD && speed_override && level_reg == $past(level_reg) - 3'h1);
    endsequence

    relay_disabled_a: assert property (!stage_en [*2] |-> relay == 4'h0)
        else $error("relay closed with no lag pumps");
    stage_thresh_a: assert property (state_reg == ST_IDLE && state_next == ST_STAGE_HOLD
        |=> level_reg == $past(level_reg) + 3'h1 && $past(below))
        else $error("stage without low value");
    stage_delay_a: assert property (state_reg == ST_IDLE && state_next == ST_STAGE_HOLD
        |-> t_stage.done || (mux_on && level_reg == 3'h0))
        else $error("stage before delay");
    dest_cond_a: assert property (dest_start_s |-> above && in_window && t_dest.done)
        else $error("destage without its conditions");
    boost_first_a: assert property (dest_start_s |-> boost_then_release_s)
        else $error("relay released before boost");
    boost_hold_a: assert property (state_reg == ST_DEST_HOLD ##1 state_reg == ST_DEST_HOLD
        |-> speed_override && $stable(speed_target))
        else $error("boost not held");
    resume_a: assert property (state_reg == ST_DEST_HOLD && t_hold.done
        |=> state_reg == ST_IDLE && !speed_override)
        else $error("override kept after boost");
    stage_cut_a: assert property (state_reg == ST_IDLE && state_next == ST_STAGE_HOLD
        |=> speed_override && speed_target == (stage_cut[16] ? 16'h0000 : stage_cut[15:0]))
        else $error("stage speed wrong");
    relay_range_a: assert property ($stable(lag_n) [*2]
        |-> (relay & ~((4'h1 << lag_n) - 4'h1)) == 4'h0)
        else $error("relay beyond lag count");
    rotate_a: assert property (primary_reg != $past(primary_reg) && $past(mux_on)
        |-> $past(t_rot.done) && $past(state_reg) == ST_IDLE)
        else $error("primary moved off schedule");
    jockey_a: assert property (($stable(cfg_reg[`IX_CTRL]) && jockey) [*2]
        |-> !relay[0] && primary_reg != 3'h1)
        else $error("jockey relay staged");
    single_a: assert property (state_reg != ST_IDLE && state_reg != ST_DEST_RAISE
        |=> level_reg == $past(level_reg) || !stage_en)
        else $error("overlapping staging actions");
endmodule // pump_stage_sequencer

// >>> test/pump_bank.sv
// far-side model: bank of relay-switched pumps, reports how many are running
// assumes relay bit g closes the contactor of drive g+1 one clock later
`timescale 1ns/1ps
module pump_bank (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // relay contacts from the sequencer
    input wire logic [3:0] relay,
    // pumps seen running
    output logic [2:0] running
);
    // contactors pull in one clock after the coil closes, like a real starter
    always_ff @(posedge clk) begin
        if (!nrst) begin
            running <= 3'h0;
        end else begin
            running <= 3'(relay[0]) + 3'(relay[1]) + 3'(relay[2]) + 3'(relay[3]);
        end
    end
endmodule // pump_bank

// >>> test/tb.sv
// self-checking bench for the pump staging sequencer: apb config, staging walks
// assumes the design answers apb with zero wait states and a short timer tick
`timescale 1ns/1ps
`include "stage_params.svh"
module tb;
    import stage_pkg::*;
    localparam int TK = 4;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr;
    logic master_run, speed_override;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] process_value, master_freq, speed_target;
    logic [3:0] relay;
    logic [2:0] running;
    logic [23:0] cfg [14];
    logic err;
    int n_mismatch, checked, seed;

    pump_stage_sequencer #(.TICK_CYCLES(TK)) dut (.clk(clk), .nrst(nrst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .process_value(process_value),
        .master_freq(master_freq), .relay(relay), .master_run(master_run),
        .speed_override(speed_override), .speed_target(speed_target));
    pump_bank bank (.clk(clk), .nrst(nrst), .relay(relay), .running(running));

    // free-running 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic summarize();
        $display("mismatches %0d comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [7:0] adr(input logic [3:0] ix);
        return {2'b00, ix, 2'b00};
    endfunction

    // expected override speeds, worked out from the config table
    function automatic logic [15:0] exp_cut();
        return (cfg[10][15:0] > cfg[13][15:0]) ? cfg[10][15:0] - cfg[13][15:0] : 16'h0000;
    endfunction

    function automatic logic [15:0] exp_boost(input logic [15:0] f);
        logic [16:0] s;
        s = {1'b0, f} + {1'b0, cfg[12][15:0]};
        return s[16] ? 16'hFFFF : s[15:0];
    endfunction

    // one apb transfer: setup, access held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            check("pready", 32'h0, 32'h1);
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // bounded wait for relay (sel 0) or speed_override (sel 1), sampled mid-cycle
    task automatic wait_out(input string name, input logic sel, input logic [3:0] exp,
                            input int bound);
        int i;
        for (i = 0; i < bound; i++) begin
            @(negedge clk);
            if ((sel ? {3'h0, speed_override} : relay) === exp) break;
        end
        check(name, (sel ? {3'h0, speed_override} : relay), exp);
        if (i == bound) summarize();
    endtask

    task automatic idle_cycles(input int n);
        repeat (n) @(negedge clk);
    endtask

    initial begin
        n_mismatch = 0;
        checked = 0;
        seed = 32'hca587ded;
        nrst = 1'b0;
        {psel, penable, pwrite} = 3'b000;
        paddr = 8'h00;
        pwdata = 32'h0;
        process_value = 16'h2000;
        master_freq = 16'h0300;
        // random thresholds within sensible spans; timers in ticks
        cfg = '{24'h0, 24'h1000 + 24'($random(seed) & 16'h0FFF), 24'h10 + 24'($random(seed) & 4'hF),
                24'h10 + 24'($random(seed) & 4'hF), 24'h3, 24'h2, 24'h2, 24'h2, 24'h0,
                24'h0400, 24'h1770, 24'h0200, 24'h0150, 24'h0100 + 24'($random(seed) & 8'hFF)};
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        check("relay_rst", relay, 4'h0);
        check("run_rst", master_run, 1'b1);
        check("ovr_rst", speed_override, 1'b0);
        // load and read back every config register except control, unmapped place refused
        for (int k = 1; k < `NUM_CFG; k++) apb(1'b1, adr(4'(k)), {8'hFF, cfg[k]});
        for (int k = 1; k < `NUM_CFG; k++) begin
            apb(1'b0, adr(4'(k)), 32'h0);
            check("cfg_rb", rd, {8'h00, cfg[k]});
            check("cfg_err", err, 1'b0);
        end
        apb(1'b0, 8'h3C, 32'h0);
        check("unmapped_err", err, 1'b1);
        check("unmapped_rd", rd, 32'h0);
        apb(1'b1, adr(`IX_STATUS), 32'hFFFF);
        apb(1'b0, adr(`IX_STATUS), 32'h0);
        check("status_ro", rd[4:0], 5'h10);
        // zero lag count: low pressure never closes a relay
        @(posedge clk) process_value <= cfg[1][15:0] - cfg[2][15:0];
        idle_cycles(40);
        check("lag0_relay", relay, 4'h0);
        check("lag0_ovr", speed_override, 1'b0);
        @(posedge clk) process_value <= cfg[1][15:0];
        apb(1'b1, adr(`IX_CTRL), 32'h2);
        // boundary dip with a lapse in the middle restarts the stage delay
        @(posedge clk) process_value <= cfg[1][15:0] - cfg[2][15:0];
        idle_cycles(2 * TK);
        check("delay_hold", relay, 4'h0);
        @(posedge clk) process_value <= cfg[1][15:0];
        idle_cycles(2);
        @(posedge clk) process_value <= cfg[1][15:0] - cfg[2][15:0];
        idle_cycles(2 * TK);
        check("delay_restart", relay, 4'h0);
        wait_out("stage_ovr", 1'b1, 4'h1, 40);
        check("stage_speed", speed_target, exp_cut());
        wait_out("stage_first", 1'b0, 4'h1, 4);
        idle_cycles(2);
        check("one_action", relay, 4'h1);
        wait_out("stage_second", 1'b0, 4'h3, 80);
        wait_out("stage_end", 1'b1, 4'h0, 40);
        idle_cycles(30);
        check("max_n", relay, 4'h3);
        check("bank", running, 3'h2);
        // destage refused outside the frequency window, taken on its edge
        @(posedge clk) process_value <= cfg[1][15:0] + cfg[3][15:0];
        master_freq <= cfg[9][15:0] + cfg[11][15:0] + 16'h1;
        idle_cycles(40);
        check("window_out", relay, 4'h3);
        @(posedge clk) master_freq <= cfg[9][15:0] + cfg[11][15:0];
        wait_out("dest_ovr", 1'b1, 4'h1, 40);
        check("boost_first", relay, 4'h3);
        check("boost_speed", speed_target, exp_boost(cfg[9][15:0] + cfg[11][15:0]));
        wait_out("dest_rev", 1'b0, 4'h1, 4);
        check("boost_hold", speed_override, 1'b1);
        wait_out("dest_end", 1'b1, 4'h0, 40);
        // jockey on relay one: staging starts at relay two
        @(posedge clk) process_value <= cfg[1][15:0];
        apb(1'b1, adr(`IX_CTRL), 32'h0);
        wait_out("shrink", 1'b0, 4'h0, 10);
        apb(1'b1, adr(`IX_CTRL), 32'hA);
        @(posedge clk) process_value <= cfg[1][15:0] - cfg[2][15:0];
        wait_out("jockey", 1'b0, 4'h2, 60);
        wait_out("jk_end", 1'b1, 4'h0, 40);
        // zero cycle time: the primary must not have moved
        apb(1'b0, adr(`IX_STATUS), 32'h0);
        check("no_rotate", rd[7:5], 3'h0);
        @(posedge clk) process_value <= cfg[1][15:0];
        apb(1'b1, adr(`IX_CTRL), 32'h0);
        // multiplex: primary steps master, slave 1, slave 2, back to master
        apb(1'b1, adr(`IX_STAGE_DELAY), 32'hC8);
        apb(1'b1, adr(`IX_CYCLE_TIME), 32'h5);
        apb(1'b1, adr(`IX_CTRL), 32'h2);
        for (int p = 1; p < 4; p++) begin
            for (int i = 0; i < 40; i++) begin
                apb(1'b0, adr(`IX_STATUS), 32'h0);
                if (rd[7:5] === 3'(p % 3)) break;
            end
            check("rotate", rd[7:5], 3'(p % 3));
        end
        for (int i = 0; i < 40; i++) begin
            apb(1'b0, adr(`IX_STATUS), 32'h0);
            if (rd[7:5] === 3'h1) break;
        end
        // slave primary skips the long delay and is called by its relay
        @(posedge clk) process_value <= cfg[1][15:0] - cfg[2][15:0];
        wait_out("primary_now", 1'b0, 4'h1, 8);
        idle_cycles(1);
        check("slave_call", running, 3'h1);
        check("master_later", master_run, 1'b0);
        summarize();
    end

    // hang guard
    initial begin
        #4000000;
        n_mismatch++;
        summarize();
    end
endmodule // tb
